//--- src/tw_timer.sv
// 8-bit timer waveform generator with two compare-output channels on Avalon-MM
`timescale 1ns/1ns
`default_nettype none
module tw_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [tw_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tw_pkg::DATA_W-1:0] avs_writedata,
  output logic [tw_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Compare output pins
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe
);
  import tw_pkg::*;

  // Register state
  logic [CNT_W-1:0] ctrl_a_reg, ctrl_a_next;
  logic [CNT_W-1:0] ctrl_b_reg, ctrl_b_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] cmp_buf_reg [NUM_CH];
  logic [CNT_W-1:0] cmp_buf_next [NUM_CH];
  logic [CNT_W-1:0] cmp_act_reg [NUM_CH];
  logic [CNT_W-1:0] cmp_act_next [NUM_CH];
  logic [2:0] status_reg, status_next;
  logic [3:0] pin_ctrl_reg, pin_ctrl_next;
  logic up_reg, up_next;
  logic block_reg, block_next;
  logic ack_reg, ack_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [NUM_CH-1:0] oc_reg, oc_next;
  logic [NUM_CH-1:0] pin_reg, pin_next;
  logic [NUM_CH-1:0] oe_reg, oe_next;

  // Decoded mode and events
  logic [2:0] wm;
  tw_mode_type mode;
  logic mode_reserved;
  logic top_is_cmp;
  logic [CNT_W-1:0] top;
  logic run;
  logic at_top;
  logic at_bottom;
  logic ovf_evt;
  logic cmp_load;
  logic [NUM_CH-1:0] match;
  // Per-channel output action fields
  logic [1:0] act [NUM_CH];
  logic wr_acc;
  logic cnt_wr;

  // Bus handshake: one wait cycle per access, taken on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_acc = avs_write & ack_reg;
  assign avs_readdata = rdata_reg;
  assign cnt_wr = wr_acc && (avs_address == COUNT_OFS);

  // Mode decode; reserved codes count as normal
  always_comb begin
    wm = {ctrl_b_reg[WM_HI_BIT], ctrl_a_reg[WM_LO_LSB +: 2]};
    mode = TW_NORMAL;
    top_is_cmp = 1'b0;
    mode_reserved = 1'b0;
    case (wm)
      WM_NORMAL: mode = TW_NORMAL;
      WM_PHASE_MAX: mode = TW_PHASE;
      WM_CTC: begin
        mode = TW_CTC;
        top_is_cmp = 1'b1;
      end
      WM_FAST_MAX: mode = TW_FAST;
      WM_PHASE_CMP: begin
        mode = TW_PHASE;
        top_is_cmp = 1'b1;
      end
      WM_FAST_CMP: begin
        mode = TW_FAST;
        top_is_cmp = 1'b1;
      end
      default: mode_reserved = 1'b1;
    endcase
  end

  // Top, bottom, match and overflow events
  always_comb begin
    run = ctrl_b_reg[RUN_BIT];
    top = top_is_cmp ? cmp_act_reg[0] : CNT_MAX;
    at_top = run && (cnt_reg == top);
    at_bottom = run && (cnt_reg == CNT_BOTTOM);
    act[0] = ctrl_a_reg[ACT_A_LSB +: 2];
    act[1] = ctrl_a_reg[ACT_B_LSB +: 2];
    for (int i = 0; i < NUM_CH; i++) begin
      // A counter write suppresses the match on the next count
      match[i] = run && !block_reg && (cnt_reg == cmp_act_reg[i]);
    end
    ovf_evt = 1'b0;
    case (wm)
      WM_PHASE_MAX, WM_PHASE_CMP: ovf_evt = at_bottom && !up_reg;
      WM_FAST_CMP: ovf_evt = at_top;
      default: ovf_evt = run && (cnt_reg == CNT_MAX);
    endcase
    // Buffered compare values load at top in phase mode, at the wrap in fast
    cmp_load = (mode == TW_PHASE || mode == TW_FAST) ? at_top : 1'b1;
  end

  // Counter and direction
  always_comb begin
    cnt_next = cnt_reg;
    up_next = up_reg;
    block_next = cnt_wr;
    if (cnt_wr) begin
      cnt_next = avs_writedata[CNT_W-1:0];
    end else if (run) begin
      if (mode == TW_PHASE) begin
        if (up_reg) begin
          if (cnt_reg >= top) begin
            up_next = 1'b0;
            cnt_next = (cnt_reg == CNT_BOTTOM) ? cnt_reg : cnt_reg - CNT_ONE;
          end else begin
            cnt_next = cnt_reg + CNT_ONE;
          end
        end else if (cnt_reg == CNT_BOTTOM) begin
          up_next = 1'b1;
          cnt_next = (top == CNT_BOTTOM) ? cnt_reg : cnt_reg + CNT_ONE;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end else begin
        up_next = 1'b1;
        // Wrap from top to bottom; normal and reserved modes wrap at max
        cnt_next = at_top ? CNT_BOTTOM : cnt_reg + CNT_ONE;
      end
    end
  end

  // Direction resets up so phase mode starts climbing from bottom
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_reg <= REG_RESET;
      up_reg <= 1'b1;
      block_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      up_reg <= up_next;
      block_reg <= block_next;
    end
  end

  // Bus handshake: one wait state per access, then the answer
  always_comb begin
    ack_next = (avs_read | avs_write) & ~ack_reg;
  end

  // Acknowledge drops after each answer so back-to-back requests wait again
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Control and pin control writes; reserved bits are masked at the write
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    pin_ctrl_next = pin_ctrl_reg;
    if (wr_acc) begin
      if (avs_address == CTRL_A_OFS) begin
        ctrl_a_next = avs_writedata[CNT_W-1:0] & CTRL_A_WMASK;
      end else if (avs_address == CTRL_B_OFS) begin
        ctrl_b_next = avs_writedata[CNT_W-1:0] & CTRL_B_WMASK;
      end else if (avs_address == PIN_CTRL_OFS) begin
        pin_ctrl_next = avs_writedata[3:0];
      end
    end
  end

  // Mode bits change only while the bus writes them
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_a_reg <= REG_RESET;
      ctrl_b_reg <= REG_RESET;
      pin_ctrl_reg <= PIN_RESET;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      pin_ctrl_reg <= pin_ctrl_next;
    end
  end

  // Compare buffers; the active copies follow at the load point
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      cmp_buf_next[i] = cmp_buf_reg[i];
      cmp_act_next[i] = cmp_load ? cmp_buf_reg[i] : cmp_act_reg[i];
    end
    if (wr_acc) begin
      if (avs_address == CMP_A_OFS) begin
        cmp_buf_next[0] = avs_writedata[CNT_W-1:0];
      end else if (avs_address == CMP_B_OFS) begin
        cmp_buf_next[1] = avs_writedata[CNT_W-1:0];
      end
    end
    // In non-PWM modes a compare write is live at once
    if (!(mode == TW_PHASE || mode == TW_FAST)) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cmp_act_next[i] = cmp_buf_next[i];
      end
    end
  end

  // Writes in PWM modes wait here, so a period never sees a torn compare
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cmp_buf_reg[i] <= REG_RESET;
        cmp_act_reg[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        cmp_buf_reg[i] <= cmp_buf_next[i];
        cmp_act_reg[i] <= cmp_act_next[i];
      end
    end
  end

  // Status flags, write one to clear
  always_comb begin
    status_next = status_reg;
    if (wr_acc && (avs_address == STATUS_OFS)) begin
      status_next = status_reg & ~avs_writedata[2:0];
    end
    // Hardware sets after software clears, so a same-cycle event survives
    if (ovf_evt) status_next[OVF_BIT] = 1'b1;
    if (match[0]) status_next[MATCH_A_BIT] = 1'b1;
    if (match[1]) status_next[MATCH_B_BIT] = 1'b1;
  end

  // Flags clear only on reset or by software
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Read mux; registered so read data come from a flip-flop
  always_comb begin
    rdata_next = '0;
    if (avs_address == CTRL_A_OFS) begin
      rdata_next[CNT_W-1:0] = ctrl_a_reg;
    end else if (avs_address == CTRL_B_OFS) begin
      rdata_next[CNT_W-1:0] = ctrl_b_reg;
    end else if (avs_address == COUNT_OFS) begin
      rdata_next[CNT_W-1:0] = cnt_reg;
    end else if (avs_address == CMP_A_OFS) begin
      rdata_next[CNT_W-1:0] = cmp_buf_reg[0];
    end else if (avs_address == CMP_B_OFS) begin
      rdata_next[CNT_W-1:0] = cmp_buf_reg[1];
    end else if (avs_address == STATUS_OFS) begin
      rdata_next[2:0] = status_reg;
    end else if (avs_address == PIN_CTRL_OFS) begin
      rdata_next[3:0] = pin_ctrl_reg;
    end
  end

  // Sampled one cycle ahead, so the answer stands at the acknowledging edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Per-channel waveform unit; channel 0 is A, channel 1 is B
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic connected;
    logic cmp_is_top;
    // Action 01 in PWM is live only for A with the mode high bit set
    always_comb begin
      connected = (act[ch] != ACT_OFF) && !mode_reserved;
      if ((mode == TW_FAST || mode == TW_PHASE) && act[ch] == ACT_TOGGLE) begin
        connected = (ch == 0) && ctrl_b_reg[WM_HI_BIT];
      end
    end

    // Waveform state of the channel
    always_comb begin
      cmp_is_top = (cmp_act_reg[ch] == top);
      oc_next[ch] = oc_reg[ch];
      if (connected) begin
        if (act[ch] == ACT_TOGGLE) begin
          if (match[ch]) oc_next[ch] = ~oc_reg[ch];
        end else if (mode == TW_FAST) begin
          // Match clears (10) or sets (11); the wrap does the opposite
          if (match[ch] && !cmp_is_top) oc_next[ch] = act[ch][0];
          if (at_top) oc_next[ch] = ~act[ch][0];
        end else if (mode == TW_PHASE) begin
          if (cmp_is_top) begin
            if (at_top) oc_next[ch] = act[ch][0];
          end else if (match[ch]) begin
            oc_next[ch] = up_reg ? act[ch][0] : ~act[ch][0];
          end
        end else if (match[ch]) begin
          oc_next[ch] = act[ch][0];
        end
      end
    end

    // Waveform keeps its level while disconnected, ready for reconnection
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        oc_reg[ch] <= 1'b0;
      end else begin
        oc_reg[ch] <= oc_next[ch];
      end
    end

    // Port value stands in while the channel is disconnected
    always_comb begin
      pin_next[ch] = connected ? oc_next[ch] : pin_ctrl_reg[PORT_LSB + ch];
      oe_next[ch] = pin_ctrl_reg[DIR_LSB + ch];
    end

    // Pins and enables reset low so nothing drives before software asks
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        pin_reg[ch] <= 1'b0;
        oe_reg[ch] <= 1'b0;
      end else begin
        pin_reg[ch] <= pin_next[ch];
        oe_reg[ch] <= oe_next[ch];
      end
    end
  end

  // Pin outputs come straight from flip-flops
  assign compare_out_a = pin_reg[0];
  assign compare_out_a_oe = oe_reg[0];
  assign compare_out_b = pin_reg[1];
  assign compare_out_b_oe = oe_reg[1];
endmodule // tw_timer
`default_nettype wire

//--- pkg/tw_pkg.sv
// Constants and types shared by the timer waveform and compare-output block
package tw_pkg;
  // Bus and counter widths, channel count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int NUM_CH = 2;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_A_OFS = 8'hB0;
  localparam logic [ADDR_W-1:0] CTRL_B_OFS = 8'hB4;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'hB8;
  localparam logic [ADDR_W-1:0] CMP_A_OFS = 8'hBC;
  localparam logic [ADDR_W-1:0] CMP_B_OFS = 8'hC0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'hC4;
  localparam logic [ADDR_W-1:0] PIN_CTRL_OFS = 8'hC8;
  // Reset values
  localparam logic [CNT_W-1:0] REG_RESET = 8'h00;
  localparam logic [3:0] PIN_RESET = 4'h0;
  // Control A layout: action A 7:6, action B 5:4, mode low 1:0
  localparam int ACT_A_LSB = 6;
  localparam int ACT_B_LSB = 4;
  localparam int WM_LO_LSB = 0;
  localparam logic [CNT_W-1:0] CTRL_A_WMASK = 8'hF3;
  // Control B layout: mode high bit, run bit
  localparam int WM_HI_BIT = 3;
  localparam int RUN_BIT = 0;
  localparam logic [CNT_W-1:0] CTRL_B_WMASK = 8'h09;
  // Status layout: write one to clear
  localparam int OVF_BIT = 0;
  localparam int MATCH_A_BIT = 1;
  localparam int MATCH_B_BIT = 2;
  // Pin control layout: direction A/B, port value A/B
  localparam int DIR_LSB = 0;
  localparam int PORT_LSB = 2;
  // Count limits and step
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  // Waveform mode codes
  localparam logic [2:0] WM_NORMAL = 3'h0;
  localparam logic [2:0] WM_PHASE_MAX = 3'h1;
  localparam logic [2:0] WM_CTC = 3'h2;
  localparam logic [2:0] WM_FAST_MAX = 3'h3;
  localparam logic [2:0] WM_PHASE_CMP = 3'h5;
  localparam logic [2:0] WM_FAST_CMP = 3'h7;
  // Output action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  // Counting behaviour classes
  typedef enum logic [1:0] {TW_NORMAL, TW_CTC, TW_FAST, TW_PHASE} tw_mode_type;
endpackage : tw_pkg

//--- verif/tw_pin_load.sv
// Port pin load model: pull-up holds the pin high when undriven
`timescale 1ns/1ns
`default_nettype none
module tw_pin_load (
  // Driver side
  input wire logic drive,
  input wire logic drive_oe,
  // Resolved pin level
  output logic level
);
  // Undriven pin floats to the pull-up, never to a stale value
  assign level = drive_oe ? drive : 1'b1;
endmodule // tw_pin_load
`default_nettype wire

//--- verif/tw_chk.sv
// Bus and pin checker for the timer waveform block
`timescale 1ns/1ns
`default_nettype none
module tw_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic [tw_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tw_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [tw_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic compare_out_a,
  input wire logic compare_out_a_oe,
  input wire logic compare_out_b,
  input wire logic compare_out_b_oe
);
  import tw_pkg::*;
  logic [7:0] ctrl_a_reg, ctrl_a_next;
  logic [3:0] pc_reg, pc_next;
  logic wr_ok, rd_ok;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Completed transfers only; a waiting request changes nothing
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && !avs_waitrequest && avs_address == CTRL_A_OFS;
  // Shadow of control A and pin control
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    pc_next = pc_reg;
    if (wr_ok && avs_address == CTRL_A_OFS) ctrl_a_next = avs_writedata[7:0] & CTRL_A_WMASK;
    if (wr_ok && avs_address == PIN_CTRL_OFS) pc_next = avs_writedata[3:0];
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_a_reg <= 8'h00;
      pc_reg <= 4'h0;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      pc_reg <= pc_next;
    end
  end
  property p_wait_new; ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest; endproperty
  a_wait_new: assert property (p_wait_new) else $error("new request not held off");
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait");
  property p_oe_a; compare_out_a_oe == $past(pc_reg[0]); endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin A enable differs from direction");
  property p_oe_b; compare_out_b_oe == $past(pc_reg[1]); endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B enable differs from direction");
  property p_port_a; ctrl_a_reg[7:6] == 2'h0 |=> compare_out_a == $past(pc_reg[2]); endproperty
  a_port_a: assert property (p_port_a) else $error("pin A not ordinary port");
  property p_port_b; ctrl_a_reg[5:4] == 2'h0 |=> compare_out_b == $past(pc_reg[3]); endproperty
  a_port_b: assert property (p_port_b) else $error("pin B not ordinary port");
  property p_rsv; rd_ok |-> avs_readdata[3:2] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("control A reserved bits nonzero");
  property p_ctrl; rd_ok |-> avs_readdata[7:0] == ctrl_a_reg; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control A readback wrong");
endmodule // tw_chk
bind tw_timer tw_chk u_chk (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .compare_out_a, .compare_out_a_oe,
  .compare_out_b, .compare_out_b_oe);
`default_nettype wire

//--- verif/timer2_waveform_and_compare_output_bench.sv
// Self-checking bench for the timer waveform block
`timescale 1ns/1ns
`default_nettype none
module timer2_waveform_and_compare_output_bench;
  import tw_pkg::*;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, rdv;
  logic out_a, out_a_oe, out_b, out_b_oe, pin_a, pin_b;
  int fails = 0, n_checks = 0, cyc = 0, ha, hb, ra, rb;
  tw_timer u_dut (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .compare_out_a(out_a), .compare_out_a_oe(out_a_oe),
    .compare_out_b(out_b), .compare_out_b_oe(out_b_oe));
  tw_pin_load u_load_a (.drive(out_a), .drive_oe(out_a_oe), .level(pin_a));
  tw_pin_load u_load_b (.drive(out_b), .drive_oe(out_b_oe), .level(pin_b));
  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard, about twice the expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    // Only the hang guard ends a wait that never answers
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Stop, load compares and mode, run, then let buffers settle
  task automatic cfg(input logic [1:0] aa, ab, input logic [2:0] m, input logic [7:0] ca, cb);
    bus(1'b1, CTRL_B_OFS, 32'h0, rdv);
    bus(1'b1, COUNT_OFS, 32'h0, rdv);
    bus(1'b1, CMP_A_OFS, {24'h00_0000, ca}, rdv);
    bus(1'b1, CMP_B_OFS, {24'h00_0000, cb}, rdv);
    bus(1'b1, CTRL_A_OFS, {24'h00_0000, aa, ab, 2'h0, m[1:0]}, rdv);
    bus(1'b1, CTRL_B_OFS, {28'h000_0000, m[2], 3'h1}, rdv);
    repeat (600) @(posedge sys_clk);
  endtask
  // Count high samples and rising edges on a pin over n cycles
  task automatic meas(input logic sel_b, input int n, output int hi, output int rises);
    logic p, c;
    hi = 0;
    rises = 0;
    @(negedge sys_clk);
    p = sel_b ? pin_b : pin_a;
    repeat (n) begin
      @(negedge sys_clk);
      c = sel_b ? pin_b : pin_a;
      if (c === 1'b1) hi++;
      if (c === 1'b1 && p === 1'b0) rises++;
      p = c;
    end
  endtask
  task automatic t_regs();
    bus(1'b0, CTRL_A_OFS, 32'h0, rdv);
    chk("ctrl_a reset", rdv, 32'h0000_0000);
    bus(1'b1, CTRL_A_OFS, 32'h0000_00FF, rdv);
    bus(1'b0, CTRL_A_OFS, 32'h0, rdv);
    chk("ctrl_a reserved", rdv, 32'h0000_00F3);
    bus(1'b0, 8'h40, 32'h0, rdv);
    chk("unmapped read", rdv, 32'h0000_0000);
    meas(1'b0, 4, ha, ra);
    chk("pin a undriven", ha, 4);
    bus(1'b1, CTRL_A_OFS, 32'h0, rdv);
    bus(1'b1, PIN_CTRL_OFS, 32'h0000_0007, rdv);
    meas(1'b0, 4, ha, ra);
    meas(1'b1, 4, hb, rb);
    chk("port a value", ha, 4);
    chk("port b value", hb, 0);
  endtask
  task automatic t_normal();
    bus(1'b1, PIN_CTRL_OFS, 32'h0000_0003, rdv);
    cfg(2'h1, 2'h3, 3'h0, 8'h10, 8'h20);
    meas(1'b0, 512, ha, ra);
    chk("normal toggle rises", ra, 1);
    chk("normal toggle high", ha, 256);
    chk("normal set", pin_b, 1'b1);
    cfg(2'h2, 2'h2, 3'h0, 8'h10, 8'h20);
    chk("normal clear", {pin_a, pin_b}, 2'h0);
  endtask
  task automatic t_ctc();
    cfg(2'h1, 2'h0, 3'h2, 8'h09, 8'h00);
    meas(1'b0, 200, ha, ra);
    chk("ctc rises", ra, 10);
    bus(1'b1, STATUS_OFS, 32'h0000_0007, rdv);
    repeat (100) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 32'h0, rdv);
    chk("ctc no overflow", rdv[0], 1'b0);
  endtask
  task automatic t_fast();
    cfg(2'h2, 2'h3, 3'h3, 8'h40, 8'h40);
    meas(1'b0, 512, ha, ra);
    meas(1'b1, 512, hb, rb);
    chk("fast period", ra, 2);
    chk("fast duty sum", ha + hb, 512);
    cfg(2'h2, 2'h2, 3'h7, 8'h63, 8'h20);
    meas(1'b1, 400, hb, rb);
    meas(1'b0, 400, ha, ra);
    chk("fast top a period", rb, 4);
    chk("fast cmp at top", ha, 400);
    bus(1'b1, STATUS_OFS, 32'h0000_0007, rdv);
    repeat (120) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 32'h0, rdv);
    chk("fast top overflow", rdv[0], 1'b1);
    cfg(2'h1, 2'h0, 3'h7, 8'h63, 8'h00);
    meas(1'b0, 400, ha, ra);
    chk("fast toggle", ra, 2);
  endtask
  task automatic t_phase();
    cfg(2'h2, 2'h3, 3'h1, 8'h40, 8'h40);
    meas(1'b0, 1020, ha, ra);
    meas(1'b1, 1020, hb, rb);
    chk("phase period", ra, 2);
    chk("phase duty sum", ha + hb, 1020);
    cfg(2'h0, 2'h2, 3'h5, 8'h31, 8'h10);
    meas(1'b1, 196, hb, rb);
    chk("phase top a period", rb, 2);
  endtask
  task automatic t_reserved();
    bus(1'b1, PIN_CTRL_OFS, 32'h0000_000F, rdv);
    cfg(2'h1, 2'h1, 3'h3, 8'h10, 8'h10);
    meas(1'b0, 256, ha, ra);
    meas(1'b1, 256, hb, rb);
    chk("fast a 01 off", ha, 256);
    chk("fast b reserved", hb, 256);
    cfg(2'h0, 2'h1, 3'h5, 8'h31, 8'h10);
    meas(1'b1, 256, hb, rb);
    chk("phase b reserved", hb, 256);
    cfg(2'h1, 2'h0, 3'h4, 8'h10, 8'h00);
    meas(1'b0, 512, ha, ra);
    chk("reserved mode", ha, 512);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_normal();
    t_ctc();
    t_fast();
    t_phase();
    t_reserved();
    finish_test();
  end
endmodule // timer2_waveform_and_compare_output_bench
`default_nettype wire
